//--- include/irq_consts.svh
// Purpose: constants for the interrupt source logic
// Assumes: AHB-Lite slave, 32-bit words, byte offsets
// Notes: offsets are byte addresses, one word each
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ==========================================================
// register byte offsets
`define OFS_MAIN 8'h00
`define OFS_SECOND 8'h04
`define OFS_THIRD 8'h08
`define OFS_TIMER 8'h0c
`define OFS_PORT 8'h10
`define OFS_CORE 8'h14
`define OFS_SAVE 8'h18
`define OFS_STACK 8'h1c

// ==========================================================
// main control fields
`define MAIN_GIE 7
`define MAIN_TOV_EN 5
`define MAIN_A_EN 4
`define MAIN_PC_EN 3
`define MAIN_TOV_FLAG 2
`define MAIN_A_FLAG 1
`define MAIN_PC_FLAG 0
// second control fields
`define SEC_EDGE_A 6
`define SEC_EDGE_B 5
`define SEC_EDGE_C 4
`define SEC_TOV_PRI 2
`define SEC_PC_PRI 0
// third control fields
`define THR_C_PRI 7
`define THR_B_PRI 6
`define THR_C_EN 4
`define THR_B_EN 3
`define THR_C_FLAG 1
`define THR_B_FLAG 0
// timer control fields in the timer register
`define TMR_WIDE 16
`define TMR_RUN 17

// ==========================================================
// reset values and return stack sizes
`define RST_MAIN 8'h00
`define RST_SECOND 8'hf5
`define RST_THIRD 8'hc0
`define RET_STACK_DEPTH 31
`define STACK_AW 5

`endif

//--- include/irq_pkg.sv
// Purpose: types for the interrupt source logic
// Assumes: consts header supplies numbers
// Notes: structs carry core context and bus phase
package irq_pkg;
    // core context captured when an interrupt is taken
    typedef struct packed {
        logic [7:0] working_register;
        logic [7:0] status;
        logic [7:0] bank_select_register;
    } context_t;

    // latched ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bus_phase_t;

    typedef enum logic [1:0] {
        st_run,
        st_sleep,
        st_enter
    } core_state_t;
endpackage

//--- logic/edge_detect.sv
// Purpose: selectable edge detector for one external pin
// Assumes: pin is synchronous to clk
// Notes: one-cycle pulse on the chosen edge
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
    // clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // pin and selection
    input wire logic pin,
    input wire logic rising,
    output logic hit
);
    logic prev_r;
    logic prev_nxt;

    // edge compare against last sample
    always_comb begin
        prev_nxt = pin;
        hit = rising ? (pin && !prev_r) : (!pin && prev_r);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_r <= pin; // a pin idling high gives no false edge
        end else if (ce) begin
            prev_r <= prev_nxt;
        end
    end
endmodule
`default_nettype wire

//--- logic/irq_sources.sv
// Purpose: interrupt sources, wake, vectoring and context save
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: core handshake by take/ack; sleep requested by core
`timescale 1ns/10ps
`default_nettype none
`include "irq_consts.svh"
module irq_sources (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // external pins
    input wire logic ext_pin_a_irq,
    input wire logic ext_pin_b_irq,
    input wire logic ext_pin_c_irq,
    input wire logic [7:0] second_io_port,
    input wire logic [3:0] port_upper_is_input,
    // core side
    input wire logic sleep_req,
    input wire logic irq_ack,
    input wire logic [20:0] core_pc,
    input wire irq_pkg::context_t core_ctx,
    input wire logic ret_pop,
    output logic sleeping_r,
    output logic irq_high_r,
    output logic irq_low_r,
    output irq_pkg::context_t saved_ctx_r,
    output logic [20:0] ret_top_r
);
    import irq_pkg::*;

    logic [7:0] main_r, main_nxt;
    logic [7:0] second_r, second_nxt;
    logic [7:0] third_r, third_nxt;
    logic [15:0] count_r, count_nxt;
    logic wide_r, wide_nxt, run_r, run_nxt;
    logic [3:0] port_old_r, port_old_nxt;
    core_state_t state_r, state_nxt;
    bus_phase_t phase_r, phase_nxt;
    logic [31:0] hrdata_nxt;
    logic irq_high_nxt, irq_low_nxt, sleeping_nxt;
    context_t saved_ctx_nxt;
    logic hit_a, hit_b, hit_c, tov, mismatch, take;
    logic pend_a, pend_b, pend_c, pend_t, pend_p, any_high, any_low, wake;
    logic [`STACK_AW-1:0] depth;
    logic [20:0] stack_top;

    // read mux sampled in the address phase
    function automatic logic [31:0] read_word(input logic [7:0] a);
        unique case (a)
            `OFS_MAIN: read_word = {24'h000000, main_r};
            `OFS_SECOND: read_word = {24'h000000, second_r};
            `OFS_THIRD: read_word = {24'h000000, third_r};
            `OFS_TIMER: read_word = {14'h0000, run_r, wide_r, count_r};
            `OFS_PORT: read_word = {24'h000000, second_io_port};
            `OFS_CORE: read_word = {24'h000000, 2'h0, depth, state_r == st_sleep};
            `OFS_SAVE: read_word = {8'h00, saved_ctx_r};
            `OFS_STACK: read_word = {11'h000, ret_top_r};
            default: read_word = 32'h00000000;
        endcase
    endfunction

    // ==========================================================
    // edge detectors for the three pins
    edge_detect u_edge_a (
        .clk(clk), .reset(reset), .ce(ce), .pin(ext_pin_a_irq),
        .rising(second_r[`SEC_EDGE_A]), .hit(hit_a)
    );
    edge_detect u_edge_b (
        .clk(clk), .reset(reset), .ce(ce), .pin(ext_pin_b_irq),
        .rising(second_r[`SEC_EDGE_B]), .hit(hit_b)
    );
    edge_detect u_edge_c (
        .clk(clk), .reset(reset), .ce(ce), .pin(ext_pin_c_irq),
        .rising(second_r[`SEC_EDGE_C]), .hit(hit_c)
    );

    // ==========================================================
    // pending terms; a cleared enable hides the request only
    always_comb begin
        tov = run_r && (wide_r ? (count_r == 16'hffff) : (count_r[7:0] == 8'hff));
        // outputs excluded; compare with value latched at last port read or write
        mismatch = |((second_io_port[7:4] ^ port_old_r) & port_upper_is_input);
        pend_a = main_r[`MAIN_A_FLAG] && main_r[`MAIN_A_EN];
        pend_b = third_r[`THR_B_FLAG] && third_r[`THR_B_EN];
        pend_c = third_r[`THR_C_FLAG] && third_r[`THR_C_EN];
        pend_t = main_r[`MAIN_TOV_FLAG] && main_r[`MAIN_TOV_EN];
        pend_p = main_r[`MAIN_PC_FLAG] && main_r[`MAIN_PC_EN];
        // pin a has no priority bit: always high
        any_high = pend_a
            || (pend_b && third_r[`THR_B_PRI])
            || (pend_c && third_r[`THR_C_PRI])
            || (pend_t && second_r[`SEC_TOV_PRI])
            || (pend_p && second_r[`SEC_PC_PRI]);
        any_low = (pend_b && !third_r[`THR_B_PRI])
            || (pend_c && !third_r[`THR_C_PRI])
            || (pend_t && !second_r[`SEC_TOV_PRI])
            || (pend_p && !second_r[`SEC_PC_PRI]);
        wake = pend_a || pend_b || pend_c || pend_p;
        take = irq_ack && (irq_high_r || irq_low_r);
    end

    // ==========================================================
    // ahb slave, control registers and flags
    always_comb begin
        phase_nxt = phase_r;
        main_nxt = main_r;
        second_nxt = second_r;
        third_nxt = third_r;
        count_nxt = count_r;
        wide_nxt = wide_r;
        run_nxt = run_r;
        port_old_nxt = port_old_r;
        hrdata_nxt = hrdata;
        if (hready) begin
            phase_nxt.valid = hsel && htrans[1];
            phase_nxt.write = hwrite;
            phase_nxt.addr = haddr;
        end
        if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata_nxt = read_word(haddr);
            if (haddr == `OFS_PORT) begin
                port_old_nxt = second_io_port[7:4];
            end
        end
        if (run_r) begin
            count_nxt = wide_r ? count_r + 16'd1 : {count_r[15:8], count_r[7:0] + 8'd1};
        end
        // software writes first, hardware sets after, so a set wins
        if (phase_r.valid && phase_r.write) begin
            unique case (phase_r.addr)
                `OFS_MAIN: main_nxt = hwdata[7:0];
                `OFS_SECOND: second_nxt = hwdata[7:0];
                `OFS_THIRD: third_nxt = hwdata[7:0] & 8'hdb;
                `OFS_TIMER: begin
                    count_nxt = hwdata[15:0];
                    wide_nxt = hwdata[`TMR_WIDE];
                    run_nxt = hwdata[`TMR_RUN];
                end
                `OFS_PORT: port_old_nxt = second_io_port[7:4];
                default: ;
            endcase
        end
        // flags latch regardless of enable until cleared
        if (hit_a) main_nxt[`MAIN_A_FLAG] = 1'b1;
        if (hit_b) third_nxt[`THR_B_FLAG] = 1'b1;
        if (hit_c) third_nxt[`THR_C_FLAG] = 1'b1;
        if (tov) main_nxt[`MAIN_TOV_FLAG] = 1'b1;
        if (mismatch) main_nxt[`MAIN_PC_FLAG] = 1'b1;
        // global enable drops on entry to the handler
        if (take) main_nxt[`MAIN_GIE] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r <= '0;
            main_r <= `RST_MAIN;
            second_r <= `RST_SECOND;
            third_r <= `RST_THIRD;
            count_r <= 16'h0000;
            wide_r <= 1'b0;
            run_r <= 1'b0;
            port_old_r <= 4'h0;
            hrdata <= 32'h00000000;
        end else if (ce) begin
            phase_r <= phase_nxt;
            main_r <= main_nxt;
            second_r <= second_nxt;
            third_r <= third_nxt;
            count_r <= count_nxt;
            wide_r <= wide_nxt;
            run_r <= run_nxt;
            port_old_r <= port_old_nxt;
            hrdata <= hrdata_nxt;
        end
    end

    // zero wait states, always okay
    always_ff @(posedge clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==========================================================
    // sleep, wake and vector request
    always_comb begin
        state_nxt = state_r;
        sleeping_nxt = 1'b0;
        irq_high_nxt = 1'b0;
        irq_low_nxt = 1'b0;
        unique case (state_r)
            st_run: begin
                if (sleep_req && !take) begin
                    state_nxt = st_enter;
                end else if (main_r[`MAIN_GIE] && !take) begin
                    irq_high_nxt = any_high;
                    irq_low_nxt = !any_high && any_low;
                end
            end
            st_enter: begin
                state_nxt = st_sleep;
                sleeping_nxt = 1'b1;
            end
            st_sleep: begin
                sleeping_nxt = !wake;
                if (wake) begin
                    state_nxt = st_run;
                end
            end
        endcase
        // vector only when global enable set; else resume after sleep
        if (state_r != st_run) begin
            irq_high_nxt = 1'b0;
            irq_low_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= st_run;
            sleeping_r <= 1'b0;
            irq_high_r <= 1'b0;
            irq_low_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            sleeping_r <= sleeping_nxt;
            irq_high_r <= irq_high_nxt;
            irq_low_r <= irq_low_nxt;
        end
    end

    // ==========================================================
    // context save on take
    always_comb begin
        saved_ctx_nxt = take ? core_ctx : saved_ctx_r;
        // software handler saves its own copy when not using fast return
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            saved_ctx_r <= '0;
            ret_top_r <= 21'h000000;
        end else if (ce) begin
            saved_ctx_r <= saved_ctx_nxt;
            ret_top_r <= stack_top;
        end
    end

    return_stack u_stack (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .push(take),
        .pop(ret_pop),
        .push_data(core_pc),
        .top_r(stack_top),
        .depth_r(depth)
    );

    // ==========================================================
    // assertions
    sequence s_pin_a_rise;
        ce && $past(ce) && second_r[`SEC_EDGE_A] && ext_pin_a_irq && !$past(ext_pin_a_irq);
    endsequence
    sequence s_taken;
        ce && take;
    endsequence

    a_pin_a_flag: assert property (@(posedge clk) disable iff (reset)
        s_pin_a_rise |=> main_r[`MAIN_A_FLAG])
        else $error("pin a edge did not set flag");
    a_edge_sel_fall: assert property (@(posedge clk) disable iff (reset)
        ce && hit_a && !second_r[`SEC_EDGE_A] |-> !ext_pin_a_irq)
        else $error("falling select hit on high pin");
    a_disabled_quiet: assert property (@(posedge clk) disable iff (reset)
        ce && !main_r[`MAIN_A_EN] && !third_r[`THR_B_EN] && !third_r[`THR_C_EN]
        && !main_r[`MAIN_TOV_EN] && !main_r[`MAIN_PC_EN] |=> !irq_high_r && !irq_low_r)
        else $error("request while all disabled");
    a_pin_a_high: assert property (@(posedge clk) disable iff (reset)
        ce && state_r == st_run && main_r[`MAIN_GIE] && pend_a && !take && !sleep_req
        |=> irq_high_r)
        else $error("pin a not high priority");
    a_tov_flag: assert property (@(posedge clk) disable iff (reset)
        ce && run_r && !wide_r && count_r[7:0] == 8'hff |=> main_r[`MAIN_TOV_FLAG])
        else $error("8-bit overflow missed");
    a_wide_flag: assert property (@(posedge clk) disable iff (reset)
        ce && run_r && wide_r && count_r == 16'hffff |=> main_r[`MAIN_TOV_FLAG])
        else $error("16-bit overflow missed");
    a_port_flag: assert property (@(posedge clk) disable iff (reset)
        ce && mismatch |=> main_r[`MAIN_PC_FLAG])
        else $error("port change missed");
    a_wake_run: assert property (@(posedge clk) disable iff (reset)
        ce && state_r == st_sleep && wake |=> state_r == st_run && !sleeping_r)
        else $error("no wake on enabled pin");
    a_no_gie_vec: assert property (@(posedge clk) disable iff (reset)
        ce && !main_r[`MAIN_GIE] |=> !irq_high_r && !irq_low_r)
        else $error("vector without global enable");
    a_ctx_save: assert property (@(posedge clk) disable iff (reset)
        s_taken |=> saved_ctx_r == $past(core_ctx))
        else $error("context not saved");
    a_stack_push: assert property (@(posedge clk) disable iff (reset)
        s_taken ##0 (depth != 5'(`RET_STACK_DEPTH)) |=> depth == $past(depth) + 5'd1)
        else $error("return address not pushed");
    a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
        ce && main_r[`MAIN_TOV_FLAG] && !(phase_r.valid && phase_r.write)
        |=> main_r[`MAIN_TOV_FLAG])
        else $error("flag dropped without write");
    // freeze, pop, sleep, pin b priority and port latch
    sequence s_popped;
        ce && ret_pop && !take && depth != 5'd0;
    endsequence
    a_stack_pop: assert property (@(posedge clk) disable iff (reset)
        s_popped |=> depth == $past(depth) - 5'd1)
        else $error("return stack not popped");
    a_ce_freeze: assert property (@(posedge clk) disable iff (reset)
        !ce |=> count_r == $past(count_r) && main_r == $past(main_r))
        else $error("registers moved while clock enable low");
    a_sleep_quiet: assert property (@(posedge clk) disable iff (reset)
        ce && state_r != st_run |=> !irq_high_r && !irq_low_r)
        else $error("request while asleep");
    a_pin_b_low: assert property (@(posedge clk) disable iff (reset)
        ce && state_r == st_run && main_r[`MAIN_GIE] && !take && !sleep_req && !any_high
        && pend_b && !third_r[`THR_B_PRI] |=> irq_low_r)
        else $error("pin b not low priority");
    a_port_latch: assert property (@(posedge clk) disable iff (reset)
        ce && hsel && htrans[1] && hready && !hwrite && haddr == `OFS_PORT
        |=> port_old_r == $past(second_io_port[7:4]))
        else $error("port value not latched on read");
endmodule
`default_nettype wire

//--- logic/return_stack.sv
// Purpose: hardware return stack for interrupt return addresses
// Assumes: one push or pop per enabled cycle
// Notes: read data comes out of a register
`timescale 1ns/10ps
`default_nettype none
`include "irq_consts.svh"
module return_stack (
    // clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // stack access
    input wire logic push,
    input wire logic pop,
    input wire logic [20:0] push_data,
    output logic [20:0] top_r,
    output logic [`STACK_AW-1:0] depth_r
);
    logic [20:0] mem [0:`RET_STACK_DEPTH-1];
    logic [`STACK_AW-1:0] depth_nxt;
    logic [20:0] top_nxt;

    // next pointer and top word; overflow is dropped, not wrapped
    always_comb begin
        depth_nxt = depth_r;
        top_nxt = top_r;
        if (push && depth_r != 5'(`RET_STACK_DEPTH)) begin
            depth_nxt = depth_r + 5'd1;
            top_nxt = push_data;
        end else if (pop && depth_r != 5'd0) begin
            depth_nxt = depth_r - 5'd1;
            top_nxt = (depth_r > 5'd1) ? mem[depth_r - 5'd2] : 21'h000000;
        end
    end

    // storage has no reset, which keeps it a plain memory
    always_ff @(posedge clk) begin
        if (ce && push && depth_r != 5'(`RET_STACK_DEPTH)) begin
            mem[depth_r] <= push_data;
        end
    end

    // pointer and output register
    always_ff @(posedge clk) begin
        if (reset) begin
            depth_r <= 5'd0;
            top_r <= 21'h000000;
        end else if (ce) begin
            depth_r <= depth_nxt;
            top_r <= top_nxt;
        end
    end
endmodule
`default_nettype wire

//--- tb/core_model.sv
// Purpose: processor core stand-in that takes interrupt requests
// Assumes: requests are levels, the take is a one-cycle pulse
// Notes: wait_cycles sets how slowly the core answers
`timescale 1ns/10ps
`default_nettype none
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control from the bench
    input wire logic take_en,
    input wire logic [2:0] wait_cycles,
    // request and answer
    input wire logic irq_high_r,
    input wire logic irq_low_r,
    output logic irq_ack
);
    // =========================================================
    // take logic
    logic [3:0] cnt_r;

    // one pulse per request, so a single take is never counted twice
    always_ff @(posedge clk) begin
        if (reset || !take_en || irq_ack || !(irq_high_r || irq_low_r)) begin
            cnt_r <= 4'h0;
            irq_ack <= 1'b0;
        end else if (cnt_r >= {1'b0, wait_cycles}) begin
            irq_ack <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- tb/interrupt_source_logic_tb.sv
// Purpose: self-checking bench for the interrupt source logic
// Assumes: zero wait bus, core stand-in answers the takes
// Notes: expected values are worked out here from bit positions
`timescale 1ns/10ps
`default_nettype none
`include "irq_consts.svh"
module interrupt_source_logic_tb;
    import irq_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hwrite = 1'b0;
    logic sleep_req = 1'b0;
    logic take_en = 1'b0;
    logic ce = 1'b1;
    logic ret_pop = 1'b0;
    logic [20:0] pcs[$];
    logic [1:0] htrans = 2'h0;
    logic [2:0] pins = 3'h0;
    logic [2:0] wait_cycles = 3'h0;
    logic [3:0] port_in = 4'hf;
    logic [7:0] haddr = 8'h0;
    logic [7:0] port = 8'h0;
    logic [20:0] core_pc = 21'h0;
    logic [31:0] hwdata = 32'h0;
    context_t core_ctx = 24'h0;
    logic hready, hresp, irq_ack, sleeping_r, irq_high_r, irq_low_r;
    logic [7:0] fa;
    logic [20:0] ret_top_r;
    logic [31:0] hrdata, q, fm;
    context_t saved_ctx_r;
    int miscompares = 0;
    int checked = 0;

    irq_sources dut_u (.clk(clk), .reset(reset), .ce(ce), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ext_pin_a_irq(pins[0]),
        .ext_pin_b_irq(pins[1]), .ext_pin_c_irq(pins[2]), .second_io_port(port),
        .port_upper_is_input(port_in), .sleep_req(sleep_req), .irq_ack(irq_ack),
        .core_pc(core_pc), .core_ctx(core_ctx), .ret_pop(ret_pop), .sleeping_r(sleeping_r),
        .irq_high_r(irq_high_r), .irq_low_r(irq_low_r), .saved_ctx_r(saved_ctx_r),
        .ret_top_r(ret_top_r));
    core_model core_u (.clk(clk), .reset(reset), .take_en(take_en),
        .wait_cycles(wait_cycles), .irq_high_r(irq_high_r), .irq_low_r(irq_low_r),
        .irq_ack(irq_ack));

    initial begin
        forever #5 clk = ~clk;
    end

    // =========================================================
    // helpers
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // entered just after an edge; never assumes a latency
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(q & m, e);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // timer from a preset count; flag and request read back
    task automatic tmr(input logic [31:0] t, input int pr, input int en, input int f);
        wr(`OFS_MAIN, 32'h80 | (en << 5));
        wr(`OFS_SECOND, pr << 2);
        wr(`OFS_TIMER, t);
        wt(6);
        rc(`OFS_MAIN, 32'h4, f << 2);
        chk({irq_high_r, irq_low_r}, (f && en) ? (pr ? 2'h2 : 2'h1) : 2'h0);
        wr(`OFS_TIMER, 32'h0);
    endtask
    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // the whole run is under a thousand cycles; far past that is a hang
    initial begin
        wt(20000);
        miscompares++;
        finish_test();
    end

    // =========================================================
    // main sequence
    initial begin
        void'($urandom(32'hbe47fffd));
        wt(3);
        reset <= 1'b0;
        wt(1);
        rc(`OFS_MAIN, 32'hff, 32'h00);
        rc(`OFS_SECOND, 32'hff, 32'hf5);
        rc(`OFS_THIRD, 32'hff, 32'hc0);
        rc(8'h40, 32'hffffffff, 32'h0);
        chk(hresp, 1'b0);
        done("reset");
        // each pin and polarity: wrong edge leaves the flag, right edge sets it
        for (int p = 0; p < 3; p++) begin
            for (int pol = 0; pol < 2; pol++) begin
                fa = (p == 0) ? `OFS_MAIN : `OFS_THIRD;
                fm = (p == 0) ? 32'h2 : 32'h1 << (p - 1);
                pins[p] <= pol[0];
                wt(3);
                wr(`OFS_SECOND, 32'h05 | (pol << (6 - p)));
                wr(`OFS_MAIN, 32'h80);
                wr(`OFS_THIRD, 32'h0);
                pins[p] <= !pol[0];
                wt(3);
                rc(fa, fm, 32'h0);
                pins[p] <= pol[0];
                wt(3);
                rc(fa, fm, fm);
                chk({irq_high_r, irq_low_r}, 2'h0);
                wt(20);
                rc(fa, fm, fm);
            end
        end
        done("edges");
        // every pin at both priority settings, taken by the core
        take_en <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            for (int pr = 0; pr < 2; pr++) begin
                pins <= 3'h0;
                core_pc <= 21'($urandom);
                core_ctx <= 24'($urandom);
                wait_cycles <= 3'($urandom);
                wt(3);
                wr(`OFS_SECOND, 32'h75);
                wr(`OFS_THIRD, 32'h0);
                wr(`OFS_MAIN, (p == 0) ? 32'h90 : 32'h80);
                wr(`OFS_THIRD, (p == 0) ? pr * 32'hc0 : (pr << (5 + p)) | (32'h4 << p));
                pins[p] <= 1'b1;
                wt(1);
                for (int i = 0; i < 20 && !(irq_high_r || irq_low_r); i++) wt(1);
                chk({irq_high_r, irq_low_r}, (p == 0 || pr != 0) ? 2'h2 : 2'h1);
                for (int i = 0; i < 20 && (irq_high_r || irq_low_r); i++) wt(1);
                wt(3);
                pcs.push_back(core_pc);
                chk(saved_ctx_r, core_ctx);
                rc(`OFS_SAVE, 32'hffffff, core_ctx);
                chk(ret_top_r, pcs[$]);
                rc(`OFS_STACK, 32'h1fffff, pcs[$]);
                rc(`OFS_CORE, 32'h3f, pcs.size() << 1);
                rc(`OFS_MAIN, 32'h80, 32'h0);
            end
        end
        take_en <= 1'b0;
        wr(`OFS_THIRD, 32'h0);
        // one pop brings back the address pushed before the last
        ret_pop <= 1'b1;
        wt(1);
        ret_pop <= 1'b0;
        void'(pcs.pop_back());
        wt(2);
        chk(ret_top_r, pcs[$]);
        done("priority");
        for (int pr = 0; pr < 2; pr++) begin
            tmr(32'h200fd, pr, 1, 1);
            tmr(32'h300fd, pr, 1, 0);
            tmr(32'h3fffd, pr, 0, 1);
        end
        // a low clock enable must hold the running count
        wr(`OFS_TIMER, 32'h20000);
        ce <= 1'b0;
        wt(5);
        ce <= 1'b1;
        rc(`OFS_TIMER, 32'h3ffff, 32'h20000);
        wr(`OFS_TIMER, 32'h0);
        done("timer");
        // pin 7 is an output and pin 2 is below the compared nibble
        wr(`OFS_SECOND, 32'h0);
        port_in <= 4'h7;
        bus(`OFS_PORT, 1'b0, 32'h0);
        wr(`OFS_MAIN, 32'h88);
        port <= 8'h84;
        wt(4);
        rc(`OFS_MAIN, 32'h1, 32'h0);
        port <= 8'hc4;
        wt(4);
        rc(`OFS_MAIN, 32'h1, 32'h1);
        chk({irq_high_r, irq_low_r}, 2'h1);
        bus(`OFS_PORT, 1'b0, 32'h0);
        wr(`OFS_MAIN, 32'h80);
        port <= 8'he4;
        wt(4);
        chk({irq_high_r, irq_low_r}, 2'h0);
        rc(`OFS_MAIN, 32'h1, 32'h1);
        bus(`OFS_PORT, 1'b0, 32'h0);
        done("port");
        // a disabled pin must not wake the core, an enabled one must
        wr(`OFS_SECOND, 32'h75);
        for (int g = 0; g < 2; g++) begin
            pins <= 3'h0;
            wt(3);
            wr(`OFS_THIRD, 32'h0);
            wr(`OFS_MAIN, 32'h10 | (g << 7));
            sleep_req <= 1'b1;
            wt(1);
            sleep_req <= 1'b0;
            wt(3);
            pins[1] <= 1'b1;
            wt(4);
            chk(sleeping_r, 1'b1);
            pins[0] <= 1'b1;
            wt(4);
            chk(sleeping_r, 1'b0);
            chk(irq_high_r, g);
        end
        done("sleep");
        finish_test();
    end
endmodule
`default_nettype wire
